/* File: dv/host_link_model.sv */
// host side of the byte link: sends frames, takes reply bytes
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  input  wire logic       i_clk,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output var logic        o_rx_valid,
  output var logic  [7:0] o_rx_byte,
  output var logic        o_tx_ready
);
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_tx_ready = 1'b0;
  end
  // line is inverted once released so a stale byte is never reused
  task send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      o_rx_valid <= 1'b1;
      o_rx_byte <= q[i];
      o_tx_ready <= 1'b0;
      @(posedge i_clk);
    end
    o_rx_valid <= 1'b0;
    o_rx_byte <= ~q[q.size()-1];
  endtask
  task get(output logic [7:0] b, output int n);
    n = 0;
    do
    begin
      o_tx_ready <= !i_slow || $urandom_range(1);
      @(posedge i_clk);
      n++;
    end while (!(o_tx_ready && i_tx_valid) && n < 3000);
    b = i_tx_byte;
  endtask
endmodule
`default_nettype wire

/* File: dv/prsc_chk_asserts.sv */
// port assertions for the page read and status command interpreter
`timescale 1ns/100ps
`default_nettype none
module prsc_chk #(
  parameter [31:0] READ_EXEC_CYCLES = 32'd4
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_rx_valid,
  input wire logic [7:0]  i_rx_byte,
  input wire logic        i_tx_ready,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_byte,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic        prev_rx;
  logic [31:0] since_rel;
  // a command byte of aah follows another byte; the release byte never does
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      prev_rx <= 1'b0;
      since_rel <= 32'h0;
    end
    else
    begin
      prev_rx <= i_rx_valid;
      if (i_rx_valid && !prev_rx && i_rx_byte == 8'haa && o_busy)
        since_rel <= 32'h1;
      else if (o_tx_valid)
        since_rel <= 32'h0;
      else if (since_rel != 32'h0)
        since_rel <= since_rel + 32'h1;
    end
  end
  sequence s_req;
    i_rx_valid && i_rx_byte == 8'h66 ##1 i_rx_valid && i_rx_byte == 8'h02
    ##1 i_rx_valid && (i_rx_byte == 8'h44 || i_rx_byte == 8'haa) ##1 i_rx_valid;
  endsequence
  property p_ready; $rose(i_penable) && i_psel |=> o_pready; endproperty
  property p_pulse; o_pready |=> !o_pready; endproperty
  property p_err; o_pslverr |-> o_pready && o_prdata == 32'h0; endproperty
  property p_hold; o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte); endproperty
  property p_gap; o_tx_valid && i_tx_ready |=> !o_tx_valid; endproperty
  property p_crc; s_req |-> ##[1:2] o_tx_valid; endproperty
  property p_delay; o_tx_valid && since_rel != 0 |-> since_rel > READ_EXEC_CYCLES; endproperty
  property p_frame; o_tx_valid |-> o_busy; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_err: assert property (p_err) else $error("bad error reply");
  a_hold: assert property (p_hold) else $error("byte dropped");
  a_gap: assert property (p_gap) else $error("no bubble");
  a_crc: assert property (p_crc) else $error("no request crc");
  a_delay: assert property (p_delay) else $error("reply too early");
  a_frame: assert property (p_frame) else $error("tx while idle");
endmodule
bind page_read_and_status_cmds prsc_chk #(.READ_EXEC_CYCLES(READ_EXEC_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_tx_ready(i_tx_ready),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .o_busy(o_busy));
`default_nettype wire

/* File: dv/test_page_read_and_status_cmds.sv */
// self-checking bench for the page read and status command interpreter
`timescale 1ns/100ps
`default_nettype none
module test_page_read_and_status_cmds;
  localparam int R = 4;
  localparam int H = 8;
  localparam [15:0] VER = 16'h3c96; // arbitrary value
  logic        i_clk = 1'b0;
  logic        i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err, slow;
  logic        i_rx_valid, i_tx_ready, o_tx_valid, o_busy, i_entropy_healthy, lock;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rdata;
  logic [7:0]  i_rx_byte, o_tx_byte, nb;
  logic [34:0] i_page_prot;
  logic [15:0] id;
  logic [4:0]  f;
  logic [7:0]  mem [288];
  logic [7:0]  exp [$];
  int          failures, checked, lat, a, pg, k, r;
  always #4 i_clk = ~i_clk;
  page_read_and_status_cmds #(.READ_EXEC_CYCLES(R), .HEALTH_CHECK_CYCLES(H),
    .VERSION_CODE(VER)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .o_tx_valid(o_tx_valid),
    .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .i_page_prot(i_page_prot),
    .i_entropy_healthy(i_entropy_healthy), .o_busy(o_busy));
  host_link_model host (.i_clk(i_clk), .i_slow(slow), .i_tx_valid(o_tx_valid),
    .i_tx_byte(o_tx_byte), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte),
    .o_tx_ready(i_tx_ready));
  task conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    rdata = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (q[i])
    begin
      c = c ^ q[i];
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return ~c;
  endfunction
  // full frame: request, its crc, release, reply checked against exp
  task run(input logic [7:0] c, input logic [7:0] p);
    logic [7:0]  b;
    logic [15:0] q;
    int          n;
    q = crc16({8'h66, 8'h02, c, p});
    host.send({8'h66, 8'h02, c, p});
    host.get(b, n);
    cmp(b, q[7:0]);
    host.get(b, n);
    cmp(b, q[15:8]);
    host.send({8'haa});
    host.get(b, lat);
    cmp(b, 8'hff);
    foreach (exp[i])
    begin
      host.get(b, n);
      cmp(b, exp[i]);
    end
    q = crc16(exp);
    host.get(b, n);
    cmp(b, q[7:0]);
    host.get(b, n);
    cmp(b, q[15:8]);
    repeat (3) @(posedge i_clk);
    cmp(o_busy, 1'b0);
  endtask
  initial
  begin
    #250000;
    failures++;
    conclude();
  end
  initial
  begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, slow} = '0;
    {i_page_prot, i_entropy_healthy} = '0;
    void'($urandom(32'h56a9));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    cmp({o_busy, o_tx_valid, o_pready, o_pslverr}, 0);
    id = $urandom;
    apb(1'b1, 12'h004, {16'h0, id});
    apb(1'b0, 12'h004, 0);
    cmp(rdata, {16'h0, id});
    apb(1'b0, 12'h0f0, 0);
    cmp(err, 1'b1);
    cmp(rdata, 32'h0000_0000);
    for (r = 0; r < 3; r++)
    begin
      i_page_prot <= r == 0 ? '0 : 35'({$urandom, $urandom});
      slow <= r[0];
      apb(1'b1, 12'h008, 0);
      k = 0;
      for (a = 0; a < 288; a++)
      begin
        pg = a / 32;
        f = pg < 7 ? i_page_prot[pg*5 +: 5] : 5'h00;
        nb = $urandom;
        apb(1'b1, 12'h00c, {24'h0, nb});
        if (!(f[4] || f[1] || (pg == 4 && f[3])))
          mem[a] = f[2] ? mem[a] & nb : nb;
        else
          k = 1;
      end
      apb(1'b0, 12'h010, 0);
      cmp(rdata[0], k[0]);
      apb(1'b1, 12'h010, 1);
      apb(1'b0, 12'h010, 0);
      cmp(rdata[0], 1'b0);
      for (pg = 0; pg < 10; pg++)
      begin
        f = pg < 7 ? i_page_prot[pg*5 +: 5] : 5'h00;
        lock = f[0] && !(pg == 4 && f[3]);
        exp = {pg < 9 ? 8'd33 : 8'd1, pg > 8 ? 8'h77 : lock ? 8'h55 : 8'haa};
        for (a = 0; a < 32 && pg < 9; a++)
          exp.push_back(lock ? 8'hff : mem[pg*32+a]);
        run(8'h44, pg[7:0]);
      end
      slow <= 1'b0;
      for (k = 0; k < 5; k++)
      begin
        pg = k > 3 ? 1 : k;
        i_entropy_healthy <= k < 4;
        exp = {8'd13, pg > 1 ? 8'h77 : 8'haa};
        for (a = 0; a < 7; a++)
          exp.push_back({3'b000, i_page_prot[a*5 +: 5]});
        exp = {exp, id[7:0], id[15:8], VER[7:0], VER[15:8],
               pg != 1 ? 8'hff : k < 4 ? 8'haa : 8'hdd};
        run(8'haa, pg[7:0]);
        cmp(lat > R + H, pg == 1);
      end
    end
    apb(1'b1, 12'h000, 1);
    exp = {8'd1, 8'h88};
    run(8'h44, 8'h00);
    run(8'haa, 8'h01);
    apb(1'b1, 12'h000, 0);
    conclude();
  end
endmodule
`default_nettype wire

/* File: rtl/page_read_and_status_cmds.v */
// page read and status command interpreter with apb register access
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "page_read_and_status_cmds_defs.vh"

module page_read_and_status_cmds #(
  parameter [31:0] READ_EXEC_CYCLES    = `READ_EXEC_CYCLES,
  parameter [31:0] HEALTH_CHECK_CYCLES = `HEALTH_CHECK_CYCLES,
  parameter [15:0] VERSION_CODE        = 16'h5a31 // value is arbitrary
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg         o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_byte,
  output reg         o_tx_valid,
  output reg  [7:0]  o_tx_byte,
  input  wire        i_tx_ready,
  input  wire [34:0] i_page_prot,
  input  wire        i_entropy_healthy,
  output reg         o_busy
);

  localparam [2:0] S_IDLE    = 3'd0;
  localparam [2:0] S_LEN     = 3'd1;
  localparam [2:0] S_CMD     = 3'd2;
  localparam [2:0] S_PARAM   = 3'd3;
  localparam [2:0] S_CRC_OUT = 3'd4;
  localparam [2:0] S_RELEASE = 3'd5;
  localparam [2:0] S_EXEC    = 3'd6;
  localparam [2:0] S_RESP    = 3'd7;

  reg  [7:0]  mem [0:`MEM_BYTES-1];
  reg  [2:0]  state;
  reg  [7:0]  cmd;
  reg  [7:0]  param;
  reg  [15:0] crc;
  reg  [5:0]  tx_idx;
  reg  [31:0] exec_cnt;
  reg  [7:0]  result;
  reg  [7:0]  resp_len;
  reg  [7:0]  health;
  reg  [1:0]  ctrl;
  reg  [15:0] customer_id;
  reg  [8:0]  mem_addr;
  reg         wr_reject;
  reg  [7:0]  resp_byte;
  reg  [7:0]  status_byte;
  reg  [7:0]  data_byte;
  reg  [31:0] next_rdata;
  reg         next_slverr;

  wire [7:0]  prot_byte [0:`PROT_PAGES-1];
  wire [3:0]  rd_page = param[3:0];
  wire [3:0]  wr_page = mem_addr[8:5];
  wire [4:0]  rd_prot = (rd_page < `PROT_PAGES) ? prot_byte[rd_page[2:0]][4:0] : 5'h00;
  wire [4:0]  wr_prot = (wr_page < `PROT_PAGES) ? prot_byte[wr_page[2:0]][4:0] : 5'h00;
  wire        disabled = ctrl[`CTRL_DISABLED];
  wire        apb_acc = i_psel & i_penable & ~o_pready;
  wire        apb_wr = i_psel & i_penable & o_pready & i_pwrite;
  wire        rx_take = i_rx_valid;
  wire        tx_done = o_tx_valid & i_tx_ready;
  wire [5:0]  last_idx = (state == S_CRC_OUT) ? 6'd1 : resp_len[5:0] + 6'd3;
  wire [8:0]  rd_addr = {rd_page, tx_idx[4:0] - 5'd3};

  genvar g;
  generate
    for (g = 0; g < `PROT_PAGES; g = g + 1)
    begin : gen_prot
      // top three bits forced to zero
      assign prot_byte[g] = {3'h0, i_page_prot[g*`PROT_BITS +: `PROT_BITS]};
    end
  endgenerate

  function [15:0] crc16_byte;
    input [15:0] c;
    input [7:0]  d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1)
        t = t[0] ? ((t >> 1) ^ `CRC_POLY) : (t >> 1);
      crc16_byte = t;
    end
  endfunction

  // read lock hides data, except on counter page 4 when its counter flag is set
  wire rd_locked = rd_prot[`PROT_RLOCK] &
                   ~(rd_page == `COUNTER_PAGE && rd_prot[`PROT_COUNTER]);

  always @*
  begin
    status_byte = 8'h00;
    data_byte = 8'h00;
    // protection read straight from store, no access check
    case (tx_idx)
      6'd3:    status_byte = prot_byte[0];
      6'd4:    status_byte = prot_byte[1];
      6'd5:    status_byte = prot_byte[2];
      6'd6:    status_byte = prot_byte[3];
      6'd7:    status_byte = prot_byte[4];
      6'd8:    status_byte = prot_byte[5];
      6'd9:    status_byte = prot_byte[6];
      6'd10:   status_byte = customer_id[7:0];
      6'd11:   status_byte = customer_id[15:8];
      6'd12:   status_byte = VERSION_CODE[7:0];
      6'd13:   status_byte = VERSION_CODE[15:8];
      6'd14:   status_byte = health;
      default: status_byte = 8'h00;
    endcase
    if (result == `RES_LOCKED)
      data_byte = `LOCK_FILL;
    else
      data_byte = mem[rd_addr];
    resp_byte = 8'h00;
    if (state == S_CRC_OUT)
      resp_byte = tx_idx[0] ? ~crc[15:8] : ~crc[7:0];
    else if (tx_idx == 6'd0)
      resp_byte = `DUMMY_BYTE;
    else if (tx_idx == 6'd1)
      resp_byte = resp_len;
    else if (tx_idx == 6'd2)
      resp_byte = result;
    else if (tx_idx == last_idx - 6'd1)
      resp_byte = ~crc[7:0];
    else if (tx_idx == last_idx)
      resp_byte = ~crc[15:8];
    else if (cmd == `CMD_STATUS)
      resp_byte = status_byte;
    else
      resp_byte = data_byte;
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= S_IDLE;
      cmd <= 8'h00;
      param <= 8'h00;
      crc <= `CRC_INIT;
      tx_idx <= 6'd0;
      exec_cnt <= 32'd0;
      result <= 8'h00;
      resp_len <= 8'h00;
      health <= `HC_NOT_RUN;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
      o_busy <= 1'b0;
    end
    else
    begin
      o_busy <= (state != S_IDLE);
      case (state)
        S_IDLE:
        begin
          if (rx_take && i_rx_byte == `CMD_START)
          begin
            crc <= crc16_byte(`CRC_INIT, i_rx_byte);
            state <= S_LEN;
          end
        end
        S_LEN:
        begin
          if (rx_take)
          begin
            crc <= crc16_byte(crc, i_rx_byte);
            // only two-byte requests belong here
            state <= (i_rx_byte == `LEN_REQUEST) ? S_CMD : S_IDLE;
          end
        end
        S_CMD:
        begin
          if (rx_take)
          begin
            crc <= crc16_byte(crc, i_rx_byte);
            cmd <= i_rx_byte;
            if (i_rx_byte == `CMD_READ_PAGE || i_rx_byte == `CMD_STATUS)
              state <= S_PARAM;
            else
              state <= S_IDLE;
          end
        end
        S_PARAM:
        begin
          if (rx_take)
          begin
            crc <= crc16_byte(crc, i_rx_byte);
            param <= i_rx_byte;
            tx_idx <= 6'd0;
            state <= S_CRC_OUT;
          end
        end
        S_RELEASE:
        begin
          if (rx_take)
          begin
            if (i_rx_byte == `RELEASE_BYTE)
            begin
              state <= S_EXEC;
              health <= `HC_NOT_RUN;
              if (cmd == `CMD_STATUS && param == 8'h01)
                exec_cnt <= READ_EXEC_CYCLES + HEALTH_CHECK_CYCLES;
              else
                exec_cnt <= READ_EXEC_CYCLES;
            end
            else
              state <= S_IDLE;
          end
        end
        S_EXEC:
        begin
          if (exec_cnt > 32'd1)
            exec_cnt <= exec_cnt - 32'd1;
          else
          begin
            tx_idx <= 6'd0;
            crc <= `CRC_INIT;
            state <= S_RESP;
            if (disabled)
            begin
              result <= `RES_DISABLED;
              resp_len <= `LEN_SHORT_RESP;
            end
            else if (cmd == `CMD_STATUS)
            begin
              resp_len <= `LEN_STATUS_RESP;
              if (param[7:1] != 7'h00)
                result <= `RES_BAD_PARAM;
              else
              begin
                result <= `RES_OK;
                if (param[0])
                  health <= i_entropy_healthy ? `HC_PASS : `HC_FAIL;
              end
            end
            else if (param[7:4] != 4'h0 || rd_page > `LAST_PAGE)
            begin
              result <= `RES_BAD_PARAM;
              resp_len <= `LEN_SHORT_RESP;
            end
            else
            begin
              resp_len <= `LEN_READ_RESP;
              result <= rd_locked ? `RES_LOCKED : `RES_OK;
            end
          end
        end
        S_CRC_OUT, S_RESP:
        begin
          if (!o_tx_valid)
          begin
            o_tx_valid <= 1'b1;
            o_tx_byte <= resp_byte;
          end
          else if (tx_done)
          begin
            o_tx_valid <= 1'b0;
            // dummy and crc bytes stay out of the sum
            if (state == S_RESP && tx_idx != 6'd0 && tx_idx < last_idx - 6'd1)
              crc <= crc16_byte(crc, o_tx_byte);
            if (tx_idx == last_idx)
            begin
              tx_idx <= 6'd0;
              state <= (state == S_CRC_OUT) ? S_RELEASE : S_IDLE;
            end
            else
              tx_idx <= tx_idx + 6'd1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // memory loader write filter
  wire wr_counter = (wr_page == `COUNTER_PAGE) & wr_prot[`PROT_COUNTER];
  wire wr_allow = ~wr_counter & ~wr_prot[`PROT_WLOCK] & ~wr_prot[`PROT_SIGNED];
  wire wr_data_hit = apb_wr & (i_paddr == `OFF_MEM_DATA);
  wire [7:0] wr_old = mem[mem_addr];
  wire [7:0] wr_new = wr_prot[`PROT_ONEWAY] ? (wr_old & i_pwdata[7:0]) : i_pwdata[7:0];

  // no authentication path here, so signed pages always refuse
  always @(posedge i_clk)
  begin
    if (wr_data_hit && wr_allow && mem_addr < `MEM_BYTES)
      mem[mem_addr] <= wr_new;
  end

  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (i_paddr)
      `OFF_CTRL:        next_rdata = {30'h0, ctrl};
      `OFF_CUSTOMER_ID: next_rdata = {16'h0, customer_id};
      `OFF_MEM_ADDR:    next_rdata = {23'h0, mem_addr};
      `OFF_MEM_DATA:    next_rdata = {24'h0, wr_old};
      `OFF_STATUS:      next_rdata = {20'h0, result, state, wr_reject};
      default:          next_slverr = 1'b1;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      ctrl <= `CTRL_RESET;
      customer_id <= `CUSTOMER_ID_RESET;
      mem_addr <= 9'h000;
      wr_reject <= 1'b0;
    end
    else
    begin
      // one wait state keeps every apb output a flop
      o_pready <= apb_acc;
      // error flag stands only with ready, never after it
      o_pslverr <= apb_acc & next_slverr;
      if (apb_acc)
        o_prdata <= i_pwrite ? 32'h0000_0000 : next_rdata;
      if (apb_wr && i_paddr == `OFF_CTRL)
        ctrl <= i_pwdata[1:0];
      if (apb_wr && i_paddr == `OFF_CUSTOMER_ID)
        customer_id <= i_pwdata[15:0];
      if (apb_wr && i_paddr == `OFF_MEM_ADDR)
        mem_addr <= i_pwdata[8:0];
      else if (wr_data_hit)
        mem_addr <= mem_addr + 9'h001;
      // a new reject beats a clear in the same cycle
      if (wr_data_hit && (!wr_allow || mem_addr >= `MEM_BYTES))
        wr_reject <= 1'b1;
      else if (apb_wr && i_paddr == `OFF_STATUS && i_pwdata[`STAT_WR_REJECT])
        wr_reject <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/page_read_and_status_cmds_defs.vh */
// constants for the page read and status command interpreter
`ifndef PAGE_READ_AND_STATUS_CMDS_DEFS_VH
`define PAGE_READ_AND_STATUS_CMDS_DEFS_VH

`define CMD_START          8'h66
`define CMD_READ_PAGE      8'h44
`define CMD_STATUS         8'haa
`define RELEASE_BYTE       8'haa
`define DUMMY_BYTE         8'hff
`define LEN_REQUEST        8'd2
`define LEN_READ_RESP      8'd33
`define LEN_STATUS_RESP    8'd13
`define LEN_SHORT_RESP     8'd1

`define RES_OK             8'haa
`define RES_LOCKED         8'h55
`define RES_BAD_PARAM      8'h77
`define RES_DISABLED       8'h88
`define LOCK_FILL          8'hff
`define HC_NOT_RUN         8'hff
`define HC_PASS            8'haa
`define HC_FAIL            8'hdd

`define CRC_POLY           16'ha001
`define CRC_INIT           16'h0000

`define PROT_SIGNED        4
`define PROT_COUNTER       3
`define PROT_ONEWAY        2
`define PROT_WLOCK         1
`define PROT_RLOCK         0
`define PROT_BITS          5
`define PROT_PAGES         7
`define COUNTER_PAGE       4'h4
`define LAST_PAGE          4'h8
`define PAGE_BYTES         32
`define MEM_BYTES          288

`define OFF_CTRL           12'h000
`define OFF_CUSTOMER_ID    12'h004
`define OFF_MEM_ADDR       12'h008
`define OFF_MEM_DATA       12'h00c
`define OFF_STATUS         12'h010
`define CTRL_DISABLED      0
`define CTRL_RESET         2'h0
`define CUSTOMER_ID_RESET  16'h0000
`define STAT_WR_REJECT     0

`define CLK_MHZ            125
`define READ_EXEC_DELAY_US     50
`define HEALTH_CHECK_DELAY_US  100
`define READ_EXEC_CYCLES       (`READ_EXEC_DELAY_US * `CLK_MHZ)
`define HEALTH_CHECK_CYCLES    (`HEALTH_CHECK_DELAY_US * `CLK_MHZ)

`endif
